/* pkg/fpsm_evt_if.sv */
// cycle-pair event carrier between the bus slave and the state core
`timescale 1ns/100ps
interface fpsm_evt_if;
  logic start;
  logic stop;
  logic cfg_ok;
  logic integrated;
  logic pair_done;
  logic pair_sync_ok;
  logic [3:0] thr_passive;
  logic [3:0] thr_fatal;
  logic [4:0] thr_p2a;
  logic [3:0] code;
  logic [3:0] cnt_fail;
  logic [4:0] cnt_ok;
  logic tx_allow;
  logic ev_change;
  modport src (output start, stop, cfg_ok, integrated, pair_done,
    pair_sync_ok, thr_passive, thr_fatal, thr_p2a,
    input code, cnt_fail, cnt_ok, tx_allow, ev_change);
  modport core (input start, stop, cfg_ok, integrated, pair_done,
    pair_sync_ok, thr_passive, thr_fatal, thr_p2a,
    output code, cnt_fail, cnt_ok, tx_allow, ev_change);
endinterface

/* pkg/fpsm_pkg.sv */
// types of the protocol state monitor
package fpsm_pkg;
  typedef enum logic [2:0] {
    FPSM_DEFAULT, FPSM_CONFIG, FPSM_READY, FPSM_ACTIVE, FPSM_PASSIVE,
    FPSM_HALT
  } fpsm_state_t;
endpackage

/* pkg/fpsm_regs.svh */
// register map, field positions and reset values of the state monitor
`ifndef FPSM_REGS_SVH
`define FPSM_REGS_SVH
// Overview of operation
// R01: config state reads 15; passed through when config valid, held when not
// R02: status bits 4 to 7 count consecutive cycle pairs without clock sync
// R03: failed count reaching passive threshold in normal active gives passive
// R04: failed count reaching fatal threshold in normal passive gives halt
// R05: bits 8 to 12 count good sync pairs, only while passive
// R06: good count reaching allow-passive-to-active threshold gives normal active
// R07: state bits 0 to 3: default 0, ready 1, active 2, passive 3, halt 4
// R08: in normal passive frames are received but transmission is suppressed
// R09: a broken run clears its counter; communication start clears both
`define FPSM_STATUS_OFS 8'h00
`define FPSM_CTRL_OFS 8'h04
`define FPSM_THRESH_OFS 8'h08
`define FPSM_IRQ_STAT_OFS 8'h0C
`define FPSM_IRQ_MASK_OFS 8'h10
`define FPSM_CNT_FAIL_LSB 4
`define FPSM_CNT_OK_LSB 8
`define FPSM_THR_PASSIVE_LSB 0
`define FPSM_THR_FATAL_LSB 4
`define FPSM_THR_P2A_LSB 8
`define FPSM_CTRL_START_BIT 0
`define FPSM_CTRL_STOP_BIT 1
`define FPSM_CTRL_CFGOK_BIT 2
`define FPSM_THRESH_RST 32'h00000A42
`define FPSM_CODE_DEFAULT 4'h0
`define FPSM_CODE_READY 4'h1
`define FPSM_CODE_ACTIVE 4'h2
`define FPSM_CODE_PASSIVE 4'h3
`define FPSM_CODE_HALT 4'h4
`define FPSM_CODE_CONFIG 4'hF
`endif

/* rtl/fpsm_core.sv */
// protocol state machine with the two synchronisation counters
`timescale 1ns/100ps
`include "fpsm_regs.svh"
module fpsm_core
  import fpsm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  fpsm_evt_if.core ev
);
  fpsm_state_t st_ff, nxt_st;
  logic [3:0] fail_ff, nxt_fail;
  logic [4:0] ok_ff, nxt_ok;

  // next state and counters
  always_comb begin
    nxt_st = st_ff;
    nxt_fail = fail_ff;
    nxt_ok = ok_ff;
    unique case (st_ff)
      FPSM_DEFAULT: begin
        if (ev.start) begin
          nxt_st = FPSM_CONFIG;
          nxt_fail = 4'h0; // R09
          nxt_ok = 5'h00; // R09
        end
      end
      FPSM_CONFIG: begin
        if (ev.cfg_ok) nxt_st = FPSM_READY; // R01
      end
      FPSM_READY: begin
        if (ev.integrated) nxt_st = FPSM_ACTIVE;
      end
      FPSM_ACTIVE: begin
        if (ev.pair_done) begin
          if (ev.pair_sync_ok) begin
            nxt_fail = 4'h0; // R09
          end else begin
            nxt_fail = (fail_ff == 4'hF) ? fail_ff : fail_ff + 4'h1; // R02
            if (nxt_fail >= ev.thr_passive) nxt_st = FPSM_PASSIVE; // R03
          end
          nxt_ok = 5'h00;
        end
      end
      FPSM_PASSIVE: begin
        if (ev.pair_done) begin
          if (ev.pair_sync_ok) begin
            nxt_fail = 4'h0; // R09
            nxt_ok = (ok_ff == 5'h1F) ? ok_ff : ok_ff + 5'h01; // R05
            if (nxt_ok >= ev.thr_p2a) begin
              nxt_st = FPSM_ACTIVE; // R06
              nxt_ok = 5'h00;
            end
          end else begin
            nxt_ok = 5'h00; // R09
            nxt_fail = (fail_ff == 4'hF) ? fail_ff : fail_ff + 4'h1; // R02
            if (nxt_fail >= ev.thr_fatal) nxt_st = FPSM_HALT; // R04
          end
        end
      end
      FPSM_HALT: ;
    endcase
    if (ev.stop) nxt_st = FPSM_DEFAULT;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= FPSM_DEFAULT;
      fail_ff <= 4'h0;
      ok_ff <= 5'h00;
    end else begin
      st_ff <= nxt_st;
      fail_ff <= nxt_fail;
      ok_ff <= nxt_ok;
    end
  end

  // state code and transmit permission
  always_comb begin
    ev.code = `FPSM_CODE_DEFAULT; // unused enum codes read as default
    unique case (st_ff)
      FPSM_DEFAULT: ev.code = `FPSM_CODE_DEFAULT; // R07
      FPSM_CONFIG: ev.code = `FPSM_CODE_CONFIG; // R01
      FPSM_READY: ev.code = `FPSM_CODE_READY;
      FPSM_ACTIVE: ev.code = `FPSM_CODE_ACTIVE;
      FPSM_PASSIVE: ev.code = `FPSM_CODE_PASSIVE;
      FPSM_HALT: ev.code = `FPSM_CODE_HALT;
    endcase
  end
  assign ev.cnt_fail = fail_ff;
  assign ev.cnt_ok = ok_ff;
  assign ev.tx_allow = (st_ff == FPSM_ACTIVE); // R08
  assign ev.ev_change = (nxt_st != st_ff);

  passive_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == FPSM_ACTIVE && ev.pair_done && !ev.pair_sync_ok && !ev.stop &&
    fail_ff + 5'h01 >= {1'b0, ev.thr_passive} && fail_ff != 4'hF
    |=> st_ff == FPSM_PASSIVE) // R03
    else $error("active did not drop to passive");
  halt_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == FPSM_PASSIVE && ev.pair_done && !ev.pair_sync_ok && !ev.stop &&
    fail_ff + 5'h01 >= {1'b0, ev.thr_fatal} && fail_ff != 4'hF
    |=> st_ff == FPSM_HALT) // R04
    else $error("passive did not go to halt");
  fail_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == FPSM_ACTIVE || st_ff == FPSM_PASSIVE) && ev.pair_done &&
    !ev.pair_sync_ok && fail_ff < 4'hE && !ev.stop
    |=> fail_ff == $past(fail_ff) + 4'h1) // R02
    else $error("failed count did not step");
  ok_only_passive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ok_ff != $past(ok_ff) && ok_ff != 5'h00
    |-> $past(st_ff) == FPSM_PASSIVE) // R05
    else $error("good count moved outside passive");
  back_active_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == FPSM_PASSIVE && ev.pair_done && ev.pair_sync_ok && !ev.stop &&
    ok_ff + 6'h01 >= {1'b0, ev.thr_p2a} && ok_ff != 5'h1F
    |=> st_ff == FPSM_ACTIVE) // R06
    else $error("passive did not return to active");
  config_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == FPSM_CONFIG && !ev.cfg_ok && !ev.stop
    |=> ev.code == `FPSM_CODE_CONFIG) // R01
    else $error("config state not held");
  start_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == FPSM_DEFAULT && ev.start && !ev.stop
    |=> fail_ff == 4'h0 && ok_ff == 5'h00 && ev.code == 4'hF) // R09
    else $error("start did not clear counters");
  no_tx_passive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.code == 4'h3 |-> !ev.tx_allow) // R08
    else $error("transmit allowed while passive");
  code_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF}) // R07
    else $error("illegal state code");
endmodule

/* rtl/fpsm_top.sv */
// protocol state monitor with its AXI4-Lite register slave
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "fpsm_regs.svh"
module fpsm_top
  import fpsm_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic integrated,
  input wire logic pair_done,
  input wire logic pair_sync_ok,
  output logic tx_enable,
  output logic irq
);
  if (ADDR_W < 5) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  fpsm_evt_if ev ();
  fpsm_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev)
  );

  // ---------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------
  logic [31:0] thr_ff, nxt_thr;
  logic cfgok_ff, nxt_cfgok;
  logic start_ff, nxt_start;
  logic stop_ff, nxt_stop;
  logic [1:0] ist_ff, nxt_ist;
  logic [1:0] imask_ff, nxt_imask;
  logic aw_ff, nxt_aw;
  logic w_ff, nxt_w;
  logic [ADDR_W-1:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic bv_ff, nxt_bv;
  logic [1:0] br_ff, nxt_br;
  logic rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0] rr_ff, nxt_rr;
  logic tx_ff, irq_ff;
  logic [31:0] status_w;
  logic do_wr;
  logic [1:0] ev_bits;

  assign ev.start = start_ff;
  assign ev.stop = stop_ff;
  assign ev.cfg_ok = cfgok_ff;
  assign ev.integrated = integrated;
  assign ev.pair_done = pair_done;
  assign ev.pair_sync_ok = pair_sync_ok;
  assign ev.thr_passive = thr_ff[`FPSM_THR_PASSIVE_LSB +: 4];
  assign ev.thr_fatal = thr_ff[`FPSM_THR_FATAL_LSB +: 4];
  assign ev.thr_p2a = thr_ff[`FPSM_THR_P2A_LSB +: 5];

  // status word: state, failed pairs, good pairs
  assign status_w = {19'h00000, ev.cnt_ok, ev.cnt_fail, ev.code}; // R02 R05 R07
  // events: bit0 state change, bit1 pair without sync
  assign ev_bits = {pair_done & ~pair_sync_ok, ev.ev_change};
  assign do_wr = aw_ff && w_ff && !bv_ff;

  // ---------------------------------------------------------------------
  // bus next-value logic
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_thr = thr_ff;
    nxt_cfgok = cfgok_ff;
    nxt_start = 1'b0;
    nxt_stop = 1'b0;
    nxt_imask = imask_ff;
    nxt_ist = ist_ff;
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_awvalid && !aw_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = 2'b00;
      unique case (awa_ff)
        `FPSM_CTRL_OFS: begin
          nxt_start = wd_ff[`FPSM_CTRL_START_BIT];
          nxt_stop = wd_ff[`FPSM_CTRL_STOP_BIT];
          nxt_cfgok = wd_ff[`FPSM_CTRL_CFGOK_BIT]; // R01
        end
        `FPSM_THRESH_OFS: nxt_thr = {19'h00000, wd_ff[12:0]};
        `FPSM_IRQ_STAT_OFS: nxt_ist = ist_ff & ~wd_ff[1:0];
        `FPSM_IRQ_MASK_OFS: nxt_imask = wd_ff[1:0];
        `FPSM_STATUS_OFS: ;
        default: nxt_br = 2'b10;
      endcase
    end
    nxt_ist = nxt_ist | ev_bits; // set wins over clear
    if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
    if (s_axi_arvalid && !rv_ff) begin
      nxt_rv = 1'b1;
      nxt_rr = 2'b00;
      unique case (s_axi_araddr)
        `FPSM_STATUS_OFS: nxt_rd = status_w;
        `FPSM_CTRL_OFS: nxt_rd = {29'h0, cfgok_ff, 2'b00};
        `FPSM_THRESH_OFS: nxt_rd = thr_ff;
        `FPSM_IRQ_STAT_OFS: nxt_rd = {30'h0, ist_ff};
        `FPSM_IRQ_MASK_OFS: nxt_rd = {30'h0, imask_ff};
        default: begin
          nxt_rd = 32'h00000000;
          nxt_rr = 2'b10;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_ff <= `FPSM_THRESH_RST;
      cfgok_ff <= 1'b0;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
      ist_ff <= 2'b00;
      imask_ff <= 2'b00;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= 32'h00000000;
      bv_ff <= 1'b0;
      br_ff <= 2'b00;
      rv_ff <= 1'b0;
      rd_ff <= 32'h00000000;
      rr_ff <= 2'b00;
      tx_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      thr_ff <= nxt_thr;
      cfgok_ff <= nxt_cfgok;
      start_ff <= nxt_start;
      stop_ff <= nxt_stop;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
      tx_ff <= ev.tx_allow; // R08
      irq_ff <= |(nxt_ist & nxt_imask);
    end
  end

  assign s_axi_awready = !aw_ff;
  assign s_axi_wready = !w_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
  assign tx_enable = tx_ff;
  assign irq = irq_ff;

  tx_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.code == 4'h3 |=> !tx_enable) // R08
    else $error("transmit enabled in passive");
endmodule

/* tb/flexray_poc_state_monitor_test.sv */
// self-checking bench of the protocol state monitor
`timescale 1ns/100ps
`include "fpsm_regs.svh"
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
  end \
end
module flexray_poc_state_monitor_test;
  import fpsm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h4675;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_enable, irq;
  logic [1:0] bresp, rresp;
  logic integrated, pair_done, pair_sync_ok;
  logic [34:0] exp_q[$];
  logic [34:0] note;
  logic [31:0] rnd;
  int error_cnt = 0;
  int checks_done = 0;

  always #12.5 aclk = ~aclk;

  fpsm_top #(.ADDR_W(8)) i_fpsm_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .integrated(integrated),
    .pair_done(pair_done), .pair_sync_ok(pair_sync_ok),
    .tx_enable(tx_enable), .irq(irq));
  fpsm_node_model i_fpsm_node_model (.aclk(aclk), .integrated(integrated),
    .pair_done(pair_done), .pair_sync_ok(pair_sync_ok));

  // ----------------------------------------------------------------
  // bus master and response monitor
  // ----------------------------------------------------------------
  // one read or write; the expected answer is noted before issuing
  task automatic bus(input logic rd, input logic [7:0] a,
    input logic [31:0] d, input logic [1:0] resp, input logic [31:0] e);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1'b1;
    pw = !rd;
    exp_q.push_back({rd, resp, e});
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    @(posedge aclk);
    araddr <= a;
    arvalid <= rd;
    rready <= rd;
    awaddr <= a;
    wdata <= d;
    wstrb <= lfsr[3:0];
    awvalid <= !rd;
    wvalid <= !rd;
    bready <= !rd;
    do begin
      @(posedge aclk);
      n++;
      if (pa && (rd ? arready : awready)) begin
        pa = 1'b0;
        arvalid <= 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!(!pa && !pw && (rd ? rvalid : bvalid)) && n < 200);
    rready <= 1'b0;
    bready <= 1'b0;
    if (n >= 200) begin
      error_cnt++;
      $display("MISMATCH t=%0t bus answer missing", $time);
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0, 2'b00, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 2'b00, 32'h0);
  endtask
  // status word from state code and both counters
  function automatic logic [31:0] stw(input logic [3:0] c,
    input logic [3:0] f, input logic [4:0] g);
    return {19'h0, g, f, c};
  endfunction
  task automatic pair(input logic ok);
    i_fpsm_node_model.send_pair(ok, int'(lfsr[1:0]));
  endtask
  // oldest note against each accepted response
  always @(posedge aclk) begin
    if ((bvalid === 1'b1 && bready) || (rvalid === 1'b1 && rready)) begin
      note = exp_q.pop_front();
      if (note[34]) begin
        `CHK(rresp, note[33:32])
        `CHK(rdata, note[31:0])
      end else begin
        `CHK(bresp, note[33:32])
      end
    end
  end

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_DEFAULT, 0, 0));
    rd(`FPSM_THRESH_OFS, `FPSM_THRESH_RST);
    bus(1'b1, 8'h14, 32'h0, 2'b10, 32'h0);
    bus(1'b0, 8'h14, 32'h0, 2'b10, 32'h0);
    wr(`FPSM_THRESH_OFS, 32'h0232);
    wr(`FPSM_CTRL_OFS, 32'h1);
    repeat (6) @(posedge aclk);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_CONFIG, 0, 0));
    wr(`FPSM_CTRL_OFS, 32'h4);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_READY, 0, 0));
    rd(`FPSM_CTRL_OFS, 32'h4);
    i_fpsm_node_model.set_integrated(1'b1);
    repeat (3) @(posedge aclk);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_ACTIVE, 0, 0));
    @(negedge aclk);
    `CHK(tx_enable, 1'b1)
    pair(1'b0);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_ACTIVE, 1, 0));
    pair(1'b0);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_PASSIVE, 2, 0));
    @(negedge aclk);
    `CHK(tx_enable, 1'b0)
    `CHK(irq, 1'b0)
    pair(1'b1);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_PASSIVE, 0, 1));
    pair(1'b1);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_ACTIVE, 0, 0));
    pair(1'b1);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_ACTIVE, 0, 0));
    wr(`FPSM_IRQ_MASK_OFS, 32'h3);
    @(negedge aclk);
    `CHK(irq, 1'b1)
    rd(`FPSM_IRQ_STAT_OFS, 32'h3);
    rd(`FPSM_IRQ_MASK_OFS, 32'h3);
    wr(`FPSM_IRQ_STAT_OFS, 32'h3);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    repeat (3) pair(1'b0);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_HALT, 3, 0));
    @(negedge aclk);
    `CHK(irq, 1'b1)
    i_fpsm_node_model.set_integrated(1'b0);
    wr(`FPSM_CTRL_OFS, 32'h2);
    wr(`FPSM_CTRL_OFS, 32'h5);
    repeat (3) @(posedge aclk);
    rd(`FPSM_STATUS_OFS, stw(`FPSM_CODE_READY, 0, 0));
    repeat (4) begin
      rnd = lfsr & 32'h1FFF;
      wr(`FPSM_THRESH_OFS, rnd);
      rd(`FPSM_THRESH_OFS, rnd);
    end
    print_verdict();
  end
endmodule

/* tb/fpsm_node_model.sv */
// cluster node model that paces even/odd cycle pairs into the monitor
`timescale 1ns/100ps
module fpsm_node_model (
  input wire logic aclk,
  output logic integrated,
  output logic pair_done,
  output logic pair_sync_ok
);
  // quiet cluster at time zero
  initial begin
    integrated = 1'b0;
    pair_done = 1'b0;
    pair_sync_ok = 1'b0;
  end
  // one pair: single-cycle pulse, then the qualifier flips so it is stale
  task automatic send_pair(input logic ok, input int gap);
    @(posedge aclk);
    pair_done <= 1'b1;
    pair_sync_ok <= ok;
    @(posedge aclk);
    pair_done <= 1'b0;
    pair_sync_ok <= ~ok;
    repeat (gap) @(posedge aclk);
  endtask
  // integration outcome seen while the monitor is in ready
  task automatic set_integrated(input logic v);
    @(posedge aclk);
    integrated <= v;
  endtask
endmodule
